//--- logic/bsw_status_windows.v
// Secondary status and memory window registers of the bridge, APB slave
//
// The APB register port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "bsw_defines.vh"

// Behaviour
// - Status bit 21 always reads 1; writes do nothing.
// - Bit 23 is 1 in forward mode with conventional secondary, else 0.
// - Bit 24 sets only when parity enable is set and a qualifying event occurs.
// - Forward: parity error receiving read data or read split response sets bit 24.
// - Forward: parity error pin low while writing data sets bit 24.
// - Forward: split completion message reporting write parity error sets bit 24.
// - Reverse: poisoned completion received or write poisoned by us sets bit 24.
// - Bits 26:25 read 01 forward, 00 reverse.
// - Bit 27: target abort signalled (forward) or completer abort sent (reverse).
// - Bit 28: target abort seen (forward) or completer abort received (reverse).
// - Bit 29: master abort seen (forward) or unsupported request received (reverse).
// - Bit 30: system error pin seen (forward) or error message received (reverse).
// - Bit 31: any parity error (forward) or poisoned packet (reverse), no enable.
// - Non-prefetchable base bits 15:4 read-write, reset 800h, bits 3:0 zero.
// - Non-prefetchable limit bits 31:20 read-write, reset 000h, bits 19:16 zero.
// - Prefetchable base bits 15:4 read-write, reset 800h.
// - Prefetchable limit bits 31:20 read-write, reset 000h.
// - Prefetchable base 3:0 and limit 19:16 read 0001.
// - Reverse: secondary parity response enable gates poisoned packets onto bit 24.
module bsw_status_windows (
  input wire core_clk,
  input wire rst,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Mode straps, asynchronous pins
  input wire reverseMode,
  input wire secondaryPciMode,
  // Bus pins, asynchronous
  input wire secondary_parity_error_n,
  input wire system_error_n,
  // Forward-mode event pulses from the transaction logic
  input wire fwdReadDataParityErr,
  input wire fwdWriteDataPhase,
  input wire fwdSplitMsgParityErr,
  input wire fwdSignalTargetAbort,
  input wire fwdTargetAbortSeen,
  input wire fwdMasterAbortSeen,
  input wire fwdParityErrDetected,
  // Reverse-mode event pulses from the transaction logic
  input wire revPoisonedCplRcvd,
  input wire revWritePoisoned,
  input wire revCplAbortSent,
  input wire revCplAbortRcvd,
  input wire revUnsupCplRcvd,
  input wire revErrMsgRcvd,
  input wire revPoisonedTlpRcvd,
  // Values for the address decoder and status observers
  output reg modeReverse,
  output reg [15:0] secStatus,
  output reg [11:0] nonprefetchBase,
  output reg [11:0] nonprefetchLimit,
  output reg [11:0] prefetchBase,
  output reg [11:0] prefetchLimit
);

  // ==========================================
  // Synchronisers for pins and straps
  wire [`BSW_SYNC_W-1:0] syncOut;
  wire revPin;
  wire secPciPin;
  wire perrLow;
  wire serrLow;

  // Pins idle high, so a reset value of ones raises no false error after reset
  bsw_sync2 #(
    .WIDTH(`BSW_SYNC_W),
    .RESET_VAL(`BSW_SYNC_IDLE)
  ) pinSync (
    .core_clk(core_clk),
    .rst(rst),
    .asyncIn({system_error_n, secondary_parity_error_n, secondaryPciMode, reverseMode}),
    .syncOut(syncOut)
  );

  assign revPin = syncOut[`BSW_SYNC_REV];
  assign secPciPin = syncOut[`BSW_SYNC_PCI];
  assign perrLow = ~syncOut[`BSW_SYNC_PERR];
  assign serrLow = ~syncOut[`BSW_SYNC_SERR];

  // ==========================================
  // Strap capture once the synchroniser holds real pin levels
  // Straps are taken once; later pin changes are ignored
  reg strapDone;
  reg fastB2b;
  reg [1:0] strapWait;

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      strapDone <= 1'b0;
      strapWait <= 2'h0;
      modeReverse <= 1'b0;
      fastB2b <= 1'b0;
    end else if (!strapDone) begin
      if (strapWait == `BSW_STRAP_SETTLE) begin
        // Two edges have passed, so the second stage now shows the straps
        strapDone <= 1'b1;
        modeReverse <= revPin;
        fastB2b <= ~revPin & secPciPin;
      end else begin
        strapWait <= strapWait + 2'h1;
      end
    end
  end

  // ==========================================
  // APB decode
  wire setupPhase;
  wire accessDone;
  wire wrDone;
  wire hitStatus;
  wire hitNp;
  wire hitPf;
  wire hitCtrl;
  wire hitAny;
  wire [`BSW_ADDR_W-1:0] addrLo;

  assign addrLo = paddr[`BSW_ADDR_W-1:0];
  assign hitStatus = (addrLo == `BSW_ADDR_SEC_STATUS);
  assign hitNp = (addrLo == `BSW_ADDR_NP_WINDOW);
  assign hitPf = (addrLo == `BSW_ADDR_PF_WINDOW);
  assign hitCtrl = (addrLo == `BSW_ADDR_BRIDGE_CTRL);
  // Upper address bits must be zero for a hit
  assign hitAny = ~|paddr[31:`BSW_ADDR_W] &
                  (hitStatus | hitNp | hitPf | hitCtrl);
  assign setupPhase = psel & ~penable;
  assign accessDone = psel & penable & pready;
  assign wrDone = accessDone & pwrite & hitAny & ~pslverr;

  // ==========================================
  // Bridge control: secondary parity response enable
  reg perrRespEn;

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      perrRespEn <= 1'b0;
    end else if (wrDone & hitCtrl) begin
      perrRespEn <= pwdata[`BSW_BIT_PERR_EN];
    end
  end

  // ==========================================
  // Event qualification per mode
  wire mdpeFwd;
  wire mdpeRev;
  wire mdpeEvent;
  reg [`BSW_FLAG_W-1:0] flagEvent;

  assign mdpeFwd = fwdReadDataParityErr |
                   (fwdWriteDataPhase & perrLow) |
                   fwdSplitMsgParityErr;
  assign mdpeRev = revPoisonedCplRcvd | revWritePoisoned |
                   revPoisonedTlpRcvd;
  // One enable gates the parity flag in both modes
  assign mdpeEvent = perrRespEn & (modeReverse ? mdpeRev : mdpeFwd);

  // Route each mode's events onto the shared flag bits; pin errors are levels
  always @* begin
    if (modeReverse) begin
      flagEvent = {revPoisonedTlpRcvd,
                   revErrMsgRcvd,
                   revUnsupCplRcvd,
                   revCplAbortRcvd,
                   revCplAbortSent};
    end else begin
      flagEvent = {fwdParityErrDetected,
                   serrLow,
                   fwdMasterAbortSeen,
                   fwdTargetAbortSeen,
                   fwdSignalTargetAbort};
    end
  end

  // ==========================================
  // Sticky status flags
  wire mdpe;
  wire [`BSW_FLAG_W-1:0] flags;
  wire clrStatus;
  wire [`BSW_FLAG_W-1:0] clrFlags;
  wire [`BSW_FLAG_W-1:0] armedEvent;
  wire armedMdpe;
  wire mdpeClr;

  assign clrStatus = wrDone & hitStatus;
  assign clrFlags = clrStatus ? pwdata[`BSW_FLAG_MSB:`BSW_FLAG_LSB] : {`BSW_FLAG_W{1'b0}};
  assign mdpeClr = clrStatus & pwdata[`BSW_BIT_MDPE];
  // Events are ignored until the mode is known, so none lands in the wrong bit
  assign armedEvent = flagEvent & {`BSW_FLAG_W{strapDone}};
  assign armedMdpe = mdpeEvent & strapDone;

  bsw_sticky_flags #(
    .WIDTH(`BSW_FLAG_W)
  ) abortFlags (
    .core_clk(core_clk),
    .rst(rst),
    .setIn(armedEvent),
    .clrIn(clrFlags),
    .flagOut(flags)
  );

  // The parity flag clears through its own bit of the status word
  bsw_sticky_flags #(
    .WIDTH(1)
  ) parityFlag (
    .core_clk(core_clk),
    .rst(rst),
    .setIn(armedMdpe),
    .clrIn(mdpeClr),
    .flagOut(mdpe)
  );

  // ==========================================
  // Window registers
  // Both halves of a window word are written together
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      nonprefetchBase <= `BSW_BASE_RESET;
      nonprefetchLimit <= `BSW_LIMIT_RESET;
      prefetchBase <= `BSW_BASE_RESET;
      prefetchLimit <= `BSW_LIMIT_RESET;
    end else begin
      if (wrDone & hitNp) begin
        nonprefetchBase <= pwdata[`BSW_BASE_MSB:`BSW_BASE_LSB];
        nonprefetchLimit <= pwdata[`BSW_LIMIT_MSB:`BSW_LIMIT_LSB];
      end
      if (wrDone & hitPf) begin
        prefetchBase <= pwdata[`BSW_BASE_MSB:`BSW_BASE_LSB];
        prefetchLimit <= pwdata[`BSW_LIMIT_MSB:`BSW_LIMIT_LSB];
      end
    end
  end

  // ==========================================
  // Read data assembly
  // Reserved bits and unimplemented bridge control bits read zero
  reg [31:0] statusWord;
  reg [31:0] npWord;
  reg [31:0] pfWord;
  reg [31:0] ctrlWord;
  reg [31:0] readWord;

  always @* begin
    statusWord = 32'h00000000;
    statusWord[`BSW_BIT_66MHZ] = 1'b1;
    statusWord[`BSW_BIT_FBB] = fastB2b;
    statusWord[`BSW_BIT_MDPE] = mdpe;
    statusWord[`BSW_DEVSEL_MSB:`BSW_DEVSEL_LSB] =
      modeReverse ? `BSW_DEVSEL_NONE : `BSW_DEVSEL_MEDIUM;
    statusWord[`BSW_FLAG_MSB:`BSW_FLAG_LSB] = flags;
    npWord = 32'h00000000;
    npWord[`BSW_BASE_MSB:`BSW_BASE_LSB] = nonprefetchBase;
    npWord[`BSW_LIMIT_MSB:`BSW_LIMIT_LSB] = nonprefetchLimit;
    pfWord = 32'h00000000;
    pfWord[`BSW_CAP_LO_MSB:`BSW_CAP_LO_LSB] = `BSW_CAP_64BIT;
    pfWord[`BSW_BASE_MSB:`BSW_BASE_LSB] = prefetchBase;
    pfWord[`BSW_CAP_HI_MSB:`BSW_CAP_HI_LSB] = `BSW_CAP_64BIT;
    pfWord[`BSW_LIMIT_MSB:`BSW_LIMIT_LSB] = prefetchLimit;
    ctrlWord = 32'h00000000;
    ctrlWord[`BSW_BIT_PERR_EN] = perrRespEn;
    if (hitStatus) begin
      readWord = statusWord;
    end else if (hitNp) begin
      readWord = npWord;
    end else if (hitPf) begin
      readWord = pfWord;
    end else if (hitCtrl) begin
      readWord = ctrlWord;
    end else begin
      readWord = 32'h00000000;
    end
  end

  // ==========================================
  // APB answer: ready in the first access cycle
  // Unmapped words answer with an error; writes to them are dropped
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else if (setupPhase) begin
      pready <= 1'b1;
      pslverr <= ~hitAny;
      prdata <= (hitAny & ~pwrite) ? readWord : 32'h00000000;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end
  end

  // ==========================================
  // Status half-word for observers
  // One edge behind the flags, for observers outside the block
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      secStatus <= 16'h0000;
    end else begin
      secStatus <= statusWord[`BSW_STATUS_MSB:`BSW_STATUS_LSB];
    end
  end

endmodule

// ==========================================
// Two-stage synchroniser for pins from outside the clock domain
module bsw_sync2 #(
  parameter WIDTH = 4,
  parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b1}}
) (
  input wire core_clk,
  input wire rst,
  input wire [WIDTH-1:0] asyncIn,
  output wire [WIDTH-1:0] syncOut
);

  reg [WIDTH-1:0] stage1;
  reg [WIDTH-1:0] stage2;

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      stage1 <= RESET_VAL;
      stage2 <= RESET_VAL;
    end else begin
      stage1 <= asyncIn;
      stage2 <= stage1;
    end
  end

  // The first stage may go metastable; nothing but the second stage reads it
  // Only the second stage leaves the module
  assign syncOut = stage2;

endmodule

// ==========================================
// Sticky flags: set by an event, cleared by software writing a one
module bsw_sticky_flags #(
  parameter WIDTH = 5
) (
  input wire core_clk,
  input wire rst,
  input wire [WIDTH-1:0] setIn,
  input wire [WIDTH-1:0] clrIn,
  output reg [WIDTH-1:0] flagOut
);

  wire [WIDTH-1:0] next_flagOut;

  // An event in the cycle of a clearing write keeps the flag set
  assign next_flagOut = (flagOut & ~clrIn) | setIn;

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      flagOut <= {WIDTH{1'b0}};
    end else begin
      flagOut <= next_flagOut;
    end
  end

endmodule
`default_nettype wire

//--- logic/bsw_defines.vh
// Register map, field positions and reset values of the bridge status and window block
`ifndef BSW_DEFINES_VH
`define BSW_DEFINES_VH

// Byte addresses of the register words
`define BSW_ADDR_SEC_STATUS 8'h1c
`define BSW_ADDR_NP_WINDOW 8'h20
`define BSW_ADDR_PF_WINDOW 8'h24
`define BSW_ADDR_BRIDGE_CTRL 8'h3c
`define BSW_ADDR_W 8

// Secondary status bit positions within the word
`define BSW_BIT_66MHZ 21
`define BSW_BIT_FBB 23
`define BSW_BIT_MDPE 24
`define BSW_DEVSEL_LSB 25
`define BSW_DEVSEL_MSB 26
`define BSW_BIT_STA 27
`define BSW_BIT_RTA 28
`define BSW_BIT_RMA 29
`define BSW_BIT_RSE 30
`define BSW_BIT_DPE 31
`define BSW_FLAG_LSB 27
`define BSW_FLAG_MSB 31
`define BSW_FLAG_W 5

// Device-select timing codes
`define BSW_DEVSEL_MEDIUM 2'h1
`define BSW_DEVSEL_NONE 2'h0

// Window fields
`define BSW_BASE_LSB 4
`define BSW_BASE_MSB 15
`define BSW_LIMIT_LSB 20
`define BSW_LIMIT_MSB 31
`define BSW_CAP_LO_LSB 0
`define BSW_CAP_LO_MSB 3
`define BSW_CAP_HI_LSB 16
`define BSW_CAP_HI_MSB 19
`define BSW_FIELD_W 12
`define BSW_BASE_RESET 12'h800
`define BSW_LIMIT_RESET 12'h000
`define BSW_CAP_64BIT 4'h1

// Bridge control: secondary parity error response enable
`define BSW_BIT_PERR_EN 16

// Synchroniser lanes, their idle level and the strap settling count
`define BSW_SYNC_W 4
`define BSW_SYNC_REV 0
`define BSW_SYNC_PCI 1
`define BSW_SYNC_PERR 2
`define BSW_SYNC_SERR 3
`define BSW_SYNC_IDLE 4'hf
`define BSW_STRAP_SETTLE 2'h2

// Status half-word within the word
`define BSW_STATUS_LSB 16
`define BSW_STATUS_MSB 31

`endif

//--- tb/bsw_sva.sv
// Port assertions of the status and window block
`timescale 1ns/1ps
`default_nettype none
module bsw_sva_check (
  input wire core_clk,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire fwdMasterAbortSeen,
  input wire modeReverse,
  input wire [15:0] secStatus,
  input wire [11:0] nonprefetchBase
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  wire rdSt = pready && !pwrite && paddr == 32'h1c;
  wire mapped = paddr[31:8] == 24'h0 && paddr[7:0] inside {8'h1c, 8'h20, 8'h24, 8'h3c};
  a_ready_setup: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_ready_single: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_unmapped_err: assert property (pready |-> pslverr == !mapped)
    else $error("slave error does not match address");
  a_speed_bit: assert property (rdSt |-> prdata[21])
    else $error("speed bit read low");
  a_decode_timing: assert property (rdSt |-> prdata[26:25] == {1'b0, !modeReverse})
    else $error("decode timing field wrong");
  a_master_abort: assert property (!modeReverse && fwdMasterAbortSeen |=> ##1 secStatus[13])
    else $error("master abort flag not set");
  a_np_base_wr: assert property (
    pready && pwrite && paddr == 32'h20 |=> nonprefetchBase == $past(pwdata[15:4]))
    else $error("window base not written");
  a_read_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside access");
  c_status_read: cover property (rdSt);
  c_refused: cover property (pready && pslverr);
  c_abort: cover property (fwdMasterAbortSeen);
endmodule
bind bsw_status_windows bsw_sva_check CHK (.core_clk(core_clk), .rst(rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .fwdMasterAbortSeen(fwdMasterAbortSeen),
  .modeReverse(modeReverse), .secStatus(secStatus), .nonprefetchBase(nonprefetchBase));
`default_nettype wire

//--- tb/bsw_event_model.sv
// Far-side model: transaction logic event pulses and the two pulled-up error pins
`timescale 1ns/1ps
`default_nettype none
module bsw_event_model (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [4:0] evCode,
  input wire logic perrLow,
  input wire logic serrLow,
  output var logic [12:0] ev,
  output wire logic secondary_parity_error_n,
  output wire logic system_error_n
);
  // Each command becomes a single-cycle pulse
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ev <= 13'h0;
    end else begin
      ev <= (evCode == 5'h0) ? 13'h0 : 13'h1 << (evCode - 5'h1);
    end
  end
  // Pulled-up pins rest high when not asserted
  assign secondary_parity_error_n = !perrLow;
  assign system_error_n = !serrLow;
endmodule
`default_nettype wire

//--- tb/bsw_status_windows_bench.sv
// Self-checking bench of the status and window block
`timescale 1ns/1ps
`default_nettype none
module bsw_status_windows_bench;
  logic core_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, rev = 0, pci = 0;
  logic perrLow = 0, serrLow = 0, wdp = 0;
  logic [31:0] paddr = 0, pwdata = 0, r, d, b, seed = 32'd7601;
  logic [4:0] evCode = 0;
  logic [12:0] ev;
  wire perrN, serrN, pready, pslverr;
  wire [31:0] prdata;
  wire mRev;
  wire [15:0] sStat;
  wire [11:0] npBase, npLim, pfBase, pfLim;
  int err_count = 0, comparisons = 0;
  int fwdMap[16] = '{0, 1, 1, 3, 4, 5, 7, 0, 0, 0, 0, 0, 0, 0, 6, 1};
  int revMap[16] = '{0, 0, 0, 0, 0, 0, 0, 1, 1, 3, 4, 5, 6, 7, 0, 0};
  bsw_event_model PEER (.core_clk(core_clk), .rst(rst), .evCode(evCode), .perrLow(perrLow),
    .serrLow(serrLow), .ev(ev), .secondary_parity_error_n(perrN), .system_error_n(serrN));
  bsw_status_windows DUT (.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .reverseMode(rev), .secondaryPciMode(pci),
    .secondary_parity_error_n(perrN), .system_error_n(serrN), .fwdReadDataParityErr(ev[0]),
    .fwdWriteDataPhase(wdp), .fwdSplitMsgParityErr(ev[1]), .fwdSignalTargetAbort(ev[2]),
    .fwdTargetAbortSeen(ev[3]), .fwdMasterAbortSeen(ev[4]), .fwdParityErrDetected(ev[5]),
    .revPoisonedCplRcvd(ev[6]), .revWritePoisoned(ev[7]), .revCplAbortSent(ev[8]),
    .revCplAbortRcvd(ev[9]), .revUnsupCplRcvd(ev[10]), .revErrMsgRcvd(ev[11]),
    .revPoisonedTlpRcvd(ev[12]), .modeReverse(mRev), .secStatus(sStat),
    .nonprefetchBase(npBase), .nonprefetchLimit(npLim), .prefetchBase(pfBase),
    .prefetchLimit(pfLim));
  initial begin
    forever #25 core_clk = ~core_clk;
  end
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // Flag bits one event code should leave in the status word
  function automatic logic [31:0] flag(input logic rv, en, input int c);
    int k;
    logic [31:0] f;
    k = rv ? revMap[c] : fwdMap[c];
    f = (k > 1) ? 32'h1 << (k + 24) : 32'h0;
    if (en && (k == 1 || (rv && c == 13))) f = f | 32'h0100_0000;
    return f;
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [31:0] a, dt, input logic xe);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= dt;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      err_count++;
      final_report();
    end
    r = prdata;
    chk("slverr", {31'h0, pslverr}, {31'h0, xe});
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [31:0] a, exp);
    apb(1'b0, a, 32'h0, 1'b0);
    chk("rdata", r, exp);
  endtask
  task automatic fire(input int c);
    if (c < 14) evCode <= 5'(c);
    serrLow <= c == 14;
    perrLow <= c == 15;
    wdp <= c == 15;
    @(posedge core_clk);
    evCode <= 5'h0;
    repeat (3) @(posedge core_clk);
    serrLow <= 1'b0;
    perrLow <= 1'b0;
    wdp <= 1'b0;
    repeat (4) @(posedge core_clk);
  endtask
  initial begin
    for (int i = 0; i < 3; i++) begin
      rev <= i == 2;
      pci <= i != 1;
      rst <= 1'b1;
      repeat (3) @(posedge core_clk);
      rst <= 1'b0;
      repeat (4) @(posedge core_clk);
      b = 32'h0020_0000 | {5'h0, i != 2 ? 2'h1 : 2'h0, 1'b0, i == 0, 23'h0};
      rd(32'h1c, b);
      chk("mode", {31'h0, mRev}, {31'h0, i == 2});
      rd(32'h20, 32'h0000_8000);
      rd(32'h24, 32'h0001_8001);
      for (int c = 1; c < 16; c++) begin
        for (int en = 0; en < 2; en++) begin
          apb(1'b1, 32'h3c, 32'(en) << 16, 1'b0);
          apb(1'b1, 32'h1c, 32'hffff_ffff, 1'b0);
          fire(c);
          rd(32'h1c, b | flag(i == 2, en, c));
          chk("sec status", {16'h0, sStat}, (b | flag(i == 2, en, c)) >> 16);
          apb(1'b1, 32'h1c, 32'h0, 1'b0);
          rd(32'h1c, b | flag(i == 2, en, c));
          apb(1'b1, 32'h1c, 32'hffff_ffff, 1'b0);
          rd(32'h1c, b);
        end
      end
      repeat (3) begin
        d = rnd();
        apb(1'b1, 32'h20, d, 1'b0);
        rd(32'h20, d & 32'hfff0_fff0);
        apb(1'b1, 32'h24, d, 1'b0);
        rd(32'h24, d & 32'hfff0_fff0 | 32'h0001_0001);
        chk("np base", {20'h0, npBase}, {20'h0, d[15:4]});
        chk("np limit", {20'h0, npLim}, {20'h0, d[31:20]});
        chk("pf base", {20'h0, pfBase}, {20'h0, d[15:4]});
        chk("pf limit", {20'h0, pfLim}, {20'h0, d[31:20]});
      end
      apb(1'b0, 32'h30, 32'h0, 1'b1);
      chk("rdata", r, 32'h0);
      apb(1'b1, 32'h120, 32'hffff_ffff, 1'b1);
      rd(32'h20, d & 32'hfff0_fff0);
      $display("test %0d done", i);
    end
    final_report();
  end
endmodule
`default_nettype wire
